// [spi_master_command_bridge_test.sv]
// Self-checking bench for the SPI master command bridge.
`timescale 1ns/1ps
module spi_master_command_bridge_test;
  logic       clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       boot = 1'b0;
  logic       cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [7:0] cmd_byte = 8'h00;
  logic       cmd_ready, rsp_valid, busy, dis, cs_n, sclk, mosi, miso, rx_tog;
  logic [7:0] rsp_byte, rx_byte, addr, base, sexp;
  logic [7:0] tx_base = 8'h00;
  logic [8:0] rexp;
  logic [8:0] rq[$];
  logic [7:0] sq[$];
  int         mismatches = 0;
  int         checks_done = 0;
  int         cs_falls = 0;
  int         seed = 26499;

  spim_bridge dut_u (.clk(clk), .ce(1'b1), .nrst(nrst), .link_clk(link_clk),
    .boot_from_host(boot), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_byte(cmd_byte), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .busy(busy),
    .master_disabled(dis), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
    .spi_miso(miso));
  spim_periph_model per_u (.spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
    .tx_base(tx_base), .spi_miso(miso), .rx_byte(rx_byte), .rx_toggle(rx_tog));

  initial forever #5 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Payload data beats count up from base, so padding past the length differs from data.
  task automatic cmd(input logic [2:0] op, input logic [7:0] b0, b1, input int nb);
    for (int i = 0; i < nb; i++) begin
      while (cmd_ready !== 1'b1) begin
        @(posedge clk);
        #1;
      end
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_byte = (i == 0) ? b0 : (i == 1) ? b1 : 8'(base + i - 2);
      @(posedge clk);
      #1;
    end
    cmd_valid = 1'b0;
    // One idle edge keeps a following command from raising valid in the same step.
    @(posedge clk);
    #1;
  endtask : cmd

  task automatic wait_idle();
    repeat (4) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    #1;
  endtask : wait_idle

  always @(negedge clk) if (rsp_valid === 1'b1) begin
    rexp = (rq.size() > 0) ? rq.pop_front() : {1'b1, 8'hXX};
    if (rexp[8]) check("rsp_byte", rexp[7:0], rsp_byte);
  end
  always @(rx_tog) if (nrst === 1'b1) begin
    sexp = (sq.size() > 0) ? sq.pop_front() : 8'hXX;
    check("spi_byte", sexp, rx_byte);
  end
  always @(negedge cs_n) if (nrst === 1'b1) cs_falls++;

  initial begin
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    addr = 8'($random(seed));
    base = 8'($random(seed));
    rq = '{{1'b1, addr}, 9'h138};
    cmd(spim_pkg::OP_READ_SETUP, addr, 8'hC8, 2);
    cmd(spim_pkg::OP_READ_QUERY, 8'h00, 8'h00, 1);
    sq = '{addr, base, 8'(base + 1), 8'(base + 2)};
    cmd(spim_pkg::OP_APPEND, addr, 8'h02, 56);
    repeat (200) @(posedge clk);
    #1 check("frames", 8'h00, 8'(cs_falls));
    base = 8'(base + 2);
    cmd(spim_pkg::OP_APPEND_EXEC, 8'h5A, 8'h01, 56);
    check("busy", 8'h01, {7'h00, busy});
    check("cmd_ready", 8'h00, {7'h00, cmd_ready});
    wait_idle();
    check("frames", 8'h01, 8'(cs_falls));
    check("spi_left", 8'h00, 8'(sq.size()));
    addr = 8'($random(seed));
    tx_base = 8'($random(seed));
    sq = '{addr, 8'h00, 8'h00};
    for (int i = 0; i < 56; i++) rq.push_back({i < 2, 8'(tx_base + i)});
    cmd(spim_pkg::OP_READ_SETUP, addr, 8'h02, 2);
    cmd(spim_pkg::OP_FETCH, 8'h00, 8'h00, 1);
    wait_idle();
    repeat (80) @(posedge clk);
    #1 check("rsp_left", 8'h00, 8'(rq.size()));
    check("sclk_idle", 8'h00, {7'h00, sclk});
    nrst = 1'b0;
    boot = 1'b1;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (6) @(posedge clk);
    #1 check("disabled", 8'h01, {7'h00, dis});
    cmd(spim_pkg::OP_APPEND_EXEC, 8'h11, 8'h01, 56);
    repeat (200) @(posedge clk);
    #1 check("frames", 8'h02, 8'(cs_falls));
    summarize();
  end

  initial begin
    #300000;
    mismatches++;
    summarize();
  end
endmodule : spi_master_command_bridge_test

// [spim_bridge.sv]
// Command-driven SPI master bridge: command side on clk, serial side on link_clk.
`timescale 1ns/1ps
module spim_bridge #(
  parameter int unsigned QUEUE_DEPTH = spim_pkg::QUEUE_BYTES,
  parameter int unsigned READ_DEPTH  = spim_pkg::READ_MAX
) (
  input  logic       clk,
  input  logic       ce,
  input  logic       nrst,
  input  logic       link_clk,
  input  logic       boot_from_host,
  input  logic       cmd_valid,
  output logic       cmd_ready,
  input  logic [2:0] cmd_op,
  input  logic [7:0] cmd_byte,
  output logic       rsp_valid,
  output logic [7:0] rsp_byte,
  output logic       busy,
  output logic       master_disabled,
  output logic       spi_cs_n,
  output logic       spi_sclk,
  output logic       spi_mosi,
  input  logic       spi_miso
);

  localparam int unsigned QW  = $clog2(QUEUE_DEPTH + 1);
  localparam int unsigned QAW = $clog2(QUEUE_DEPTH);
  localparam int unsigned RAW = $clog2(READ_DEPTH);
  localparam logic [spim_pkg::HALF_W-1:0] HALF_LAST  =
    spim_pkg::HALF_W'(spim_pkg::SCK_HALF_CYC - 1);
  localparam logic [spim_pkg::HALF_W-1:0] GUARD_LAST =
    spim_pkg::HALF_W'(spim_pkg::CS_GUARD_CYC - 1);
  localparam logic [spim_pkg::HALF_W-1:0] HALF_ONE   = spim_pkg::HALF_W'(1);

  ////////////////////////////////////////////////////////////////////////////////
  // Command domain declarations.

  logic                  boot_s1_reg;
  logic                  boot_s2_reg;
  logic                  strap_seen_reg;
  logic                  disabled_reg;
  spim_pkg::spim_cstate_e cst_reg;
  logic [5:0]            beat_reg;
  logic [2:0]            op_reg;
  logic [2:0]            op_now;
  logic                  beat_fire;
  logic                  last_beat;
  logic [5:0]            data_pos;
  logic                  q_wr;
  logic                  exec_go;
  logic                  fetch_go;
  logic                  start_go;
  logic [QW-1:0]         q_fill_reg;
  logic [7:0]            q_addr_reg;
  logic [7:0]            pl_len_reg;
  logic [7:0]            rd_addr_reg;
  logic [7:0]            rd_cnt_reg;
  logic                  xfer_rd_reg;
  logic [7:0]            xfer_addr_reg;
  logic [QW-1:0]         xfer_len_reg;
  logic                  start_tgl_reg;
  logic                  dn_s1_reg;
  logic                  dn_s2_reg;
  logic                  dn_s3_reg;
  logic                  done_pulse;
  logic [5:0]            rep_idx_reg;
  logic [5:0]            rep_len_reg;
  logic                  rep_qry_reg;
  logic                  rep_v1_reg;
  logic [5:0]            rep_idx_d_reg;
  logic                  rsp_valid_reg;
  logic [7:0]            rsp_byte_reg;
  logic [7:0]            rbuf_rdata;

  // Link domain declarations.
  logic                  lrst_s1_reg;
  logic                  lrst_s2_reg;
  logic                  lce_s1_reg;
  logic                  lce_s2_reg;
  logic                  lnrst;
  logic                  lce;
  logic                  st_s1_reg;
  logic                  st_s2_reg;
  logic                  st_s3_reg;
  logic                  lstart;
  logic                  mi_s1_reg;
  logic                  mi_s2_reg;
  spim_pkg::spim_lstate_e lst_reg;
  logic [spim_pkg::HALF_W-1:0] half_reg;
  logic [2:0]            bit_reg;
  logic [QW-1:0]         idx_reg;
  logic                  is_rd_reg;
  logic [QW-1:0]         len_reg;
  logic [7:0]            shift_out_reg;
  logic [7:0]            shift_in_reg;
  logic                  cs_n_reg;
  logic                  sclk_reg;
  logic                  mosi_reg;
  logic                  done_tgl_reg;
  logic                  fall;
  logic                  byte_end;
  logic                  rb_we;
  logic [7:0]            q_rdata;
  logic [7:0]            hi_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Boot strap capture: sampled once after reset so a booted-over-SPI part stays off.

  always_ff @(posedge clk) begin
    boot_s1_reg <= boot_from_host;
    boot_s2_reg <= boot_s1_reg;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      strap_seen_reg <= 1'h0;
      disabled_reg   <= 1'h0;
    end else if (ce && !strap_seen_reg) begin
      strap_seen_reg <= 1'h1;
      disabled_reg   <= boot_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command beats. Every command is a fixed number of byte beats; padding is absorbed.

  assign cmd_ready = (cst_reg == spim_pkg::C_IDLE);
  assign beat_fire = cmd_valid && cmd_ready && ce;
  assign op_now    = (beat_reg == spim_pkg::PL_ADDR_POS) ? cmd_op : op_reg;
  assign last_beat = beat_fire && (beat_reg == spim_pkg::spim_op_beats(op_now) - 6'h01);
  assign data_pos  = beat_reg - spim_pkg::PL_DATA_POS;
  assign exec_go   = last_beat && (op_now == spim_pkg::OP_APPEND_EXEC);
  assign fetch_go  = last_beat && (op_now == spim_pkg::OP_FETCH);
  assign start_go  = (exec_go || fetch_go) && !disabled_reg;

  // Only bytes inside the length field enter the queue, and never past its end.
  assign q_wr = beat_fire && spim_pkg::spim_is_append(op_now)
             && (beat_reg >= spim_pkg::PL_DATA_POS)
             && ({2'h0, data_pos} < pl_len_reg)
             && (q_fill_reg < QW'(QUEUE_DEPTH));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      beat_reg <= 6'h00;
      op_reg   <= 3'h0;
    end else if (beat_fire) begin
      op_reg   <= op_now;
      beat_reg <= last_beat ? 6'h00 : beat_reg + 6'h01;
    end
  end

  // Payload header: the address of the first payload of a queue is the one sent.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_addr_reg <= 8'h00;
      pl_len_reg <= 8'h00;
    end else if (beat_fire && spim_pkg::spim_is_append(op_now)) begin
      if (beat_reg == spim_pkg::PL_ADDR_POS && q_fill_reg == '0) begin
        q_addr_reg <= cmd_byte;
      end
      if (beat_reg == spim_pkg::PL_LEN_POS) begin
        pl_len_reg <= cmd_byte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_fill_reg <= '0;
    end else if (ce) begin
      if ((cst_reg == spim_pkg::C_BUSY && done_pulse && !xfer_rd_reg)
          || (exec_go && disabled_reg)) begin
        q_fill_reg <= '0;
      end else if (q_wr) begin
        q_fill_reg <= q_fill_reg + QW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_addr_reg <= spim_pkg::RST_RD_ADDR;
      rd_cnt_reg  <= spim_pkg::RST_RD_COUNT;
    end else if (beat_fire && op_now == spim_pkg::OP_READ_SETUP) begin
      if (beat_reg == spim_pkg::PL_ADDR_POS) begin
        rd_addr_reg <= cmd_byte;
      end else if (cmd_byte > 8'(READ_DEPTH)) begin
        rd_cnt_reg <= 8'(READ_DEPTH);
      end else begin
        rd_cnt_reg <= cmd_byte;
      end
    end
  end

  // Transfer parameters stay still from the start toggle until done returns.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      xfer_rd_reg   <= 1'h0;
      xfer_addr_reg <= 8'h00;
      xfer_len_reg  <= '0;
      start_tgl_reg <= 1'h0;
    end else if (start_go) begin
      start_tgl_reg <= ~start_tgl_reg;
      xfer_rd_reg   <= fetch_go;
      xfer_addr_reg <= fetch_go ? rd_addr_reg : q_addr_reg;
      xfer_len_reg  <= fetch_go ? QW'(rd_cnt_reg) : q_fill_reg + QW'(q_wr);
    end
  end

  always_ff @(posedge clk) begin
    dn_s1_reg <= done_tgl_reg;
    dn_s2_reg <= dn_s1_reg;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dn_s3_reg <= 1'h0;
    end else if (ce) begin
      dn_s3_reg <= dn_s2_reg;
    end
  end

  assign done_pulse = dn_s2_reg ^ dn_s3_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencing and reply stream.

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cst_reg     <= spim_pkg::C_IDLE;
      rep_idx_reg <= 6'h00;
      rep_len_reg <= 6'h00;
      rep_qry_reg <= 1'h0;
    end else if (ce) begin
      case (cst_reg)
        spim_pkg::C_IDLE: begin
          rep_idx_reg <= 6'h00;
          if (start_go) begin
            cst_reg <= spim_pkg::C_BUSY;
          end else if (fetch_go) begin
            cst_reg     <= spim_pkg::C_REPLY;
            rep_len_reg <= 6'(READ_DEPTH);
            rep_qry_reg <= 1'h0;
          end else if (last_beat && op_now == spim_pkg::OP_READ_QUERY) begin
            cst_reg     <= spim_pkg::C_REPLY;
            rep_len_reg <= 6'(spim_pkg::SETUP_BEATS);
            rep_qry_reg <= 1'h1;
          end
        end
        spim_pkg::C_BUSY: begin
          if (done_pulse) begin
            cst_reg     <= xfer_rd_reg ? spim_pkg::C_REPLY : spim_pkg::C_IDLE;
            rep_len_reg <= 6'(READ_DEPTH);
            rep_qry_reg <= 1'h0;
          end
        end
        spim_pkg::C_REPLY: begin
          rep_idx_reg <= rep_idx_reg + 6'h01;
          if (rep_idx_reg == rep_len_reg - 6'h01) begin
            cst_reg <= spim_pkg::C_IDLE;
          end
        end
        default: cst_reg <= spim_pkg::C_IDLE;
      endcase
    end
  end

  // The buffer read is registered, so answers trail the index by two cycles.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rep_v1_reg    <= 1'h0;
      rep_idx_d_reg <= 6'h00;
      rsp_valid_reg <= 1'h0;
      rsp_byte_reg  <= 8'h00;
    end else if (ce) begin
      rep_v1_reg    <= (cst_reg == spim_pkg::C_REPLY);
      rep_idx_d_reg <= rep_idx_reg;
      rsp_valid_reg <= rep_v1_reg;
      if (rep_v1_reg) begin
        if (!rep_qry_reg) begin
          rsp_byte_reg <= rbuf_rdata;
        end else if (rep_idx_d_reg == 6'h00) begin
          rsp_byte_reg <= rd_addr_reg;
        end else begin
          rsp_byte_reg <= rd_cnt_reg;
        end
      end
    end
  end

  assign rsp_valid       = rsp_valid_reg;
  assign rsp_byte        = rsp_byte_reg;
  assign busy            = (cst_reg != spim_pkg::C_IDLE);
  assign master_disabled = disabled_reg;

  spim_dpram #(.WIDTH(8), .DEPTH(QUEUE_DEPTH)) u_queue (
    .wclk  (clk),
    .we    (q_wr),
    .waddr (q_fill_reg[QAW-1:0]),
    .wdata (cmd_byte),
    .rclk  (link_clk),
    .re    (lce),
    .raddr (idx_reg[QAW-1:0]),
    .rdata (q_rdata)
  );

  spim_dpram #(.WIDTH(8), .DEPTH(READ_DEPTH)) u_rbuf (
    .wclk  (link_clk),
    .we    (rb_we),
    .waddr (RAW'(idx_reg - QW'(1))),
    .wdata ({shift_in_reg[6:0], mi_s2_reg}),
    .rclk  (clk),
    .re    (ce),
    .raddr (rep_idx_reg[RAW-1:0]),
    .rdata (rbuf_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain synchronisers.

  always_ff @(posedge link_clk) begin
    lrst_s1_reg <= nrst;
    lrst_s2_reg <= lrst_s1_reg;
    lce_s1_reg  <= ce;
    lce_s2_reg  <= lce_s1_reg;
    st_s1_reg   <= start_tgl_reg;
    st_s2_reg   <= st_s1_reg;
    mi_s1_reg   <= spi_miso;
    mi_s2_reg   <= mi_s1_reg;
  end

  assign lnrst = lrst_s2_reg;
  assign lce   = lce_s2_reg;

  always_ff @(posedge link_clk) begin
    if (!lnrst) begin
      st_s3_reg <= 1'h0;
    end else if (lce) begin
      st_s3_reg <= st_s2_reg;
    end
  end

  assign lstart   = st_s2_reg ^ st_s3_reg;
  assign fall     = (lst_reg == spim_pkg::L_SHIFT) && (half_reg == HALF_LAST) && sclk_reg;
  assign byte_end = fall && (bit_reg == 3'h7);
  assign rb_we    = lce && byte_end && is_rd_reg && (idx_reg != '0);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: one select assertion spans address and every data byte.

  always_ff @(posedge link_clk) begin
    if (!lnrst) begin
      lst_reg      <= spim_pkg::L_IDLE;
      half_reg     <= '0;
      bit_reg      <= 3'h0;
      idx_reg      <= '0;
      cs_n_reg     <= 1'h1;
      sclk_reg     <= 1'h0;
      done_tgl_reg <= 1'h0;
    end else if (lce) begin
      case (lst_reg)
        spim_pkg::L_IDLE: begin
          if (lstart) begin
            cs_n_reg <= 1'h0;
            half_reg <= '0;
            bit_reg  <= 3'h0;
            idx_reg  <= '0;
            lst_reg  <= spim_pkg::L_SETUP;
          end
        end
        spim_pkg::L_SETUP: begin
          if (half_reg == HALF_LAST) begin
            half_reg <= '0;
            sclk_reg <= 1'h1;
            lst_reg  <= spim_pkg::L_SHIFT;
          end else begin
            half_reg <= half_reg + HALF_ONE;
          end
        end
        spim_pkg::L_SHIFT: begin
          if (half_reg != HALF_LAST) begin
            half_reg <= half_reg + HALF_ONE;
          end else begin
            half_reg <= '0;
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              bit_reg <= bit_reg + 3'h1;
              if (bit_reg == 3'h7 && idx_reg == len_reg) begin
                lst_reg <= spim_pkg::L_HOLD;
              end else if (bit_reg == 3'h7) begin
                idx_reg <= idx_reg + QW'(1);
              end
            end
          end
        end
        spim_pkg::L_HOLD: begin
          if (half_reg == GUARD_LAST) begin
            cs_n_reg     <= 1'h1;
            done_tgl_reg <= ~done_tgl_reg;
            lst_reg      <= spim_pkg::L_IDLE;
          end else begin
            half_reg <= half_reg + HALF_ONE;
          end
        end
        default: lst_reg <= spim_pkg::L_IDLE;
      endcase
    end
  end

  // Data path: output changes on the falling edge, input is taken at the same moment,
  // which is late in the high phase and clear of the synchroniser delay.
  always_ff @(posedge link_clk) begin
    if (!lnrst) begin
      is_rd_reg     <= 1'h0;
      len_reg       <= '0;
      shift_out_reg <= 8'h00;
      shift_in_reg  <= 8'h00;
      mosi_reg      <= 1'h0;
    end else if (lce) begin
      if (lst_reg == spim_pkg::L_IDLE && lstart) begin
        is_rd_reg     <= xfer_rd_reg;
        len_reg       <= xfer_len_reg;
        shift_out_reg <= xfer_addr_reg;
        mosi_reg      <= xfer_addr_reg[7];
      end else if (fall) begin
        shift_in_reg <= {shift_in_reg[6:0], mi_s2_reg};
        if (byte_end && idx_reg == len_reg) begin
          mosi_reg <= 1'h0;
        end else if (byte_end) begin
          shift_out_reg <= is_rd_reg ? 8'h00 : q_rdata;
          mosi_reg      <= is_rd_reg ? 1'h0 : q_rdata[7];
        end else begin
          shift_out_reg <= {shift_out_reg[6:0], 1'h0};
          mosi_reg      <= shift_out_reg[6];
        end
      end
    end
  end

  assign spi_cs_n = cs_n_reg;
  assign spi_sclk = sclk_reg;
  assign spi_mosi = mosi_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  always_ff @(posedge link_clk) begin
    if (!lnrst) begin
      hi_cnt_reg <= 8'h00;
    end else if (lce) begin
      hi_cnt_reg <= sclk_reg ? hi_cnt_reg + 8'h01 : 8'h00;
    end
  end

  a_sclk_framed: assert property (@(posedge link_clk) disable iff (!lnrst)
    sclk_reg |-> !cs_n_reg) else $error("Serial clock high outside chip select.");
  a_half_period: assert property (@(posedge link_clk) disable iff (!lnrst)
    $fell(sclk_reg) |-> hi_cnt_reg == 8'(spim_pkg::SCK_HALF_CYC))
    else $error("Serial clock high phase has the wrong length.");
  a_read_quiet: assert property (@(posedge link_clk) disable iff (!lnrst)
    (lst_reg == spim_pkg::L_SHIFT) && is_rd_reg && (idx_reg != '0) |-> !mosi_reg)
    else $error("Output line driven during read data.");
  a_msb_lead: assert property (@(posedge link_clk) disable iff (!lnrst)
    $rose(sclk_reg) |-> mosi_reg == shift_out_reg[7])
    else $error("Output bit is not the top bit of the shift register.");
  a_mosi_steady: assert property (@(posedge link_clk) disable iff (!lnrst)
    sclk_reg && $past(sclk_reg) |-> $stable(mosi_reg))
    else $error("Output line changed while clock high.");
  a_cs_lead: assert property (@(posedge link_clk) disable iff (!lnrst)
    $fell(cs_n_reg) |-> !sclk_reg [*4]) else $error("Chip select lead time too short.");
  a_cs_trail: assert property (@(posedge link_clk) disable iff (!lnrst)
    $rose(cs_n_reg) |-> !$past(sclk_reg, 1) && !$past(sclk_reg, 2)
      && !$past(sclk_reg, 3) && !$past(sclk_reg, 4))
    else $error("Chip select trail time too short.");
  a_read_bound: assert property (@(posedge link_clk) disable iff (!lnrst)
    rb_we |-> idx_reg <= QW'(READ_DEPTH)) else $error("Read buffer written past its end.");
  a_frame_end: assert property (@(posedge link_clk) disable iff (!lnrst)
    $rose(cs_n_reg) |-> $past(lst_reg) == spim_pkg::L_HOLD)
    else $error("Chip select released before the transfer ended.");
  a_fill_cap: assert property (@(posedge clk) disable iff (!nrst)
    q_fill_reg <= QW'(QUEUE_DEPTH)) else $error("Queue fill beyond its depth.");
  a_append_quiet: assert property (@(posedge clk) disable iff (!nrst)
    last_beat && op_now == spim_pkg::OP_APPEND |=> $stable(start_tgl_reg))
    else $error("Queue append started a transfer.");
  a_exec_start: assert property (@(posedge clk) disable iff (!nrst)
    exec_go && !disabled_reg |=> $changed(start_tgl_reg) && cst_reg == spim_pkg::C_BUSY)
    else $error("Append and execute did not start a transfer.");
  a_boot_block: assert property (@(posedge clk) disable iff (!nrst)
    disabled_reg |=> $stable(start_tgl_reg)) else $error("Disabled master started a transfer.");
  a_queue_flush: assert property (@(posedge clk) disable iff (!nrst)
    ce && cst_reg == spim_pkg::C_BUSY && done_pulse && !xfer_rd_reg |=> q_fill_reg == '0)
    else $error("Queue not emptied after execute.");

endmodule : spim_bridge

// [spim_dpram.sv]
// Two-clock byte memory with a registered read port.
`timescale 1ns/1ps
module spim_dpram #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 128,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  logic             wclk,
  input  logic             we,
  input  logic [AW-1:0]    waddr,
  input  logic [WIDTH-1:0] wdata,
  input  logic             rclk,
  input  logic             re,
  input  logic [AW-1:0]    raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge wclk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge rclk) begin
    if (re) begin
      rdata <= mem_q[raddr];
    end
  end

endmodule : spim_dpram

// [spim_periph_model.sv]
// Behavioural SPI peripheral that records sent bytes and returns a counting pattern.
`timescale 1ns/1ps
module spim_periph_model (
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_mosi,
  input  wire logic [7:0] tx_base,
  output logic            spi_miso,
  output logic [7:0]      rx_byte,
  output logic            rx_toggle
);
  int         bits = 0;
  logic [7:0] shift = 8'h00;
  logic [7:0] tx_cur;
  initial begin
    rx_byte = 8'h00;
    rx_toggle = 1'b0;
    spi_miso = 1'b0;
  end
  always @(negedge spi_cs_n) bits = 0;
  always @(posedge spi_sclk) if (spi_cs_n === 1'b0) begin
    shift = {shift[6:0], spi_mosi};
    bits++;
    if (bits % 8 == 0) begin
      rx_byte = shift;
      rx_toggle = ~rx_toggle;
    end
  end
  // Changing on the falling edge keeps the bit stable across the next rising edge.
  always @(negedge spi_sclk) if (spi_cs_n === 1'b0 && bits >= 8) begin
    tx_cur = 8'(tx_base + bits / 8 - 1);
    spi_miso = tx_cur[7 - bits % 8];
  end
  // The line has no pull, so once released it shows the inverse of the last bit.
  always @(posedge spi_cs_n) spi_miso = ~spi_miso;
endmodule : spim_periph_model

// [spim_pkg.sv]
// Constants, types and decode helpers shared by the SPI master command bridge.
// Functional notes
// - One chip-select line frames every transfer on the peripheral port.
// - Serial clock runs at a fixed one megabit per second.
// - A transfer is a read or a write, never full duplex.
// - Every byte travels most significant bit first.
// - Mode zero: clock idles low, data sampled on the rising edge.
// - Chip select leads first clock and trails last clock by 20 ns or more.
// - One read returns at most 56 bytes into the read buffer.
// - Queued payloads build writes of up to 128 bytes.
// - An executed transfer stays inside one continuous chip-select assertion.
// - Queue-append stores its payload and starts no transfer.
// - Append-and-execute stores its payload then sends the whole queue.
// - Read-setup stores peripheral address and byte count for the next read.
// - Read-setup query returns the stored address and byte count.
// - Buffer fetch returns 56 values; values past the count are undefined.
// - A write sends an address byte then data bytes under one select.
// - Only the data bytes named by the length field reach the port.
// - One payload carries address, length and at most 54 data bytes.
// - The master is disabled when the device was booted over SPI.
package spim_pkg;

  localparam int unsigned LINK_PERIOD_PS = 6000;
  localparam int unsigned SCK_HALF_PS    = 500000;
  localparam int unsigned CS_GUARD_PS    = 20000;
  localparam int unsigned SCK_HALF_CYC   = SCK_HALF_PS / LINK_PERIOD_PS;
  localparam int unsigned CS_GUARD_CYC   = (CS_GUARD_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int unsigned HALF_W         = $clog2(SCK_HALF_CYC + 1);

  localparam int unsigned PAYLOAD_BYTES  = 56;
  localparam int unsigned SETUP_BEATS    = 2;
  localparam int unsigned QUEUE_BYTES    = 128;
  localparam int unsigned READ_MAX       = 56;

  localparam logic [5:0] PL_ADDR_POS     = 6'h00;
  localparam logic [5:0] PL_LEN_POS      = 6'h01;
  localparam logic [5:0] PL_DATA_POS     = 6'h02;

  localparam logic [7:0] RST_RD_ADDR     = 8'h00;
  localparam logic [7:0] RST_RD_COUNT    = 8'h00;

  localparam logic [2:0] OP_READ_SETUP   = 3'h0;
  localparam logic [2:0] OP_READ_QUERY   = 3'h1;
  localparam logic [2:0] OP_APPEND       = 3'h2;
  localparam logic [2:0] OP_APPEND_EXEC  = 3'h3;
  localparam logic [2:0] OP_FETCH        = 3'h4;

  typedef enum logic [2:0] {
    C_IDLE  = 3'b001,
    C_BUSY  = 3'b010,
    C_REPLY = 3'b100
  } spim_cstate_e;

  typedef enum logic [3:0] {
    L_IDLE  = 4'b0001,
    L_SETUP = 4'b0010,
    L_SHIFT = 4'b0100,
    L_HOLD  = 4'b1000
  } spim_lstate_e;

  function automatic logic spim_is_append(input logic [2:0] op);
    spim_is_append = (op == OP_APPEND) || (op == OP_APPEND_EXEC);
  endfunction : spim_is_append

  function automatic logic [5:0] spim_op_beats(input logic [2:0] op);
    if (spim_is_append(op)) begin
      spim_op_beats = 6'(PAYLOAD_BYTES);
    end else if (op == OP_READ_SETUP) begin
      spim_op_beats = 6'(SETUP_BEATS);
    end else begin
      spim_op_beats = 6'h01;
    end
  endfunction : spim_op_beats

endpackage : spim_pkg
